/* File: logic/rcsl_consts.svh */
// Offsets, reset values and timing counts of the status lamp block
`ifndef RCSL_CONSTS_SVH
`define RCSL_CONSTS_SVH

// Clock period of sys_clk in ns
`define RCSL_CLK_NS 8
// Half period of the shared flash pattern in ns
`define RCSL_FLASH_HALF_NS 250000000
// Half flash period in clock cycles
`define RCSL_FLASH_HALF_CYC (`RCSL_FLASH_HALF_NS / `RCSL_CLK_NS)
// Length of the lamp test in ns
`define RCSL_TEST_NS 2000000000
// Lamp test length in clock cycles
`define RCSL_TEST_CYC (`RCSL_TEST_NS / `RCSL_CLK_NS)

// Register byte offsets
`define RCSL_CTRL_OFF 12'h000
`define RCSL_FLAGS_OFF 12'h004
`define RCSL_STATUS_OFF 12'h008

// Bit positions of the write-one event fields
`define RCSL_CTRL_INSERT_BIT 7
`define RCSL_FLAGS_CARD_BIT 10

// Register reset values
`define RCSL_CTRL_RST 32'h0000_0000
`define RCSL_FLAGS_RST 32'h0000_0000

// Number of flashes of the fault lamp after a card loss
`define RCSL_BURST_FLASHES 2'h3

`endif

/* File: logic/rcsl_pkg.sv */
// Types shared by the status lamp block
package rcsl_pkg;

	// Operating state of one CPU; codes 6 and 7 are illegal
	typedef enum logic [2:0] {
		OPS_STOP, OPS_STARTUP, OPS_SYNCUP, OPS_RUN_SYNCUP, OPS_RUN,
		OPS_RUN_RED
	} rcsl_opstate_type;

	// System state of the redundant pair
	typedef enum logic [2:0] {
		SYS_STOP, SYS_STARTUP, SYS_SYNCUP, SYS_RUN_SOLO, SYS_RUN_RED
	} rcsl_sysstate_type;

	// Lamp test sequencer states
	typedef enum logic {LT_TEST, LT_NORMAL} rcsl_ltstate_type;

	// The four front-panel status lamps
	typedef struct packed {
		logic opGreen;
		logic opYellow;
		logic faultRed;
		logic serviceYellow;
	} rcsl_lamps_type;

	// One two-colour lamp
	typedef struct packed {
		logic green;
		logic yellow;
	} rcsl_bicolor_type;

	// Control register layout
	typedef struct packed {
		logic [23:0] rsvd;
		logic insertTest;
		logic backupRole;
		rcsl_opstate_type partnerState;
		rcsl_opstate_type ownState;
	} rcsl_ctrl_type;

	// Condition flag register layout
	typedef struct packed {
		logic [20:0] rsvd;
		logic cardFail;
		logic diagEvent;
		logic energyPause;
		logic forceActive;
		logic maintDemand;
		logic syncupWait;
		logic defective;
		logic warmRestart;
		logic fwUpdated;
		logic internalAct;
		logic initDone;
	} rcsl_flags_type;

	// APB request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} rcsl_apb_req_type;

	// APB answer to the master
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} rcsl_apb_rsp_type;

endpackage

/* File: logic/rcsl_flash_gen.sv */
// Shared flash phase generator for all lamps
`timescale 1ns/1ps

module rcsl_flash_gen #(
	parameter int unsigned HALF_CYC = 4
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Flash phase and its edges
	output logic flashPhase,
	output logic risePulse,
	output logic fallPulse
);

	logic [31:0] cnt_r; // Cycles in current half period
	logic phase_r; // Lamp-on half when high
	logic wrap; // Last cycle of a half period

	assign wrap = (cnt_r == 32'(HALF_CYC - 1));
	assign flashPhase = phase_r;
	// Pulses announce the phase change at the next edge
	assign risePulse = wrap && !phase_r;
	assign fallPulse = wrap && phase_r;

	////////////////////////////////////////////////////////////////
	// Divider: one phase for every lamp keeps them in step
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 32'h0000_0000;
			phase_r <= 1'b0;
		end else if (wrap) begin
			cnt_r <= 32'h0000_0000;
			phase_r <= !phase_r;
		end else begin
			cnt_r <= cnt_r + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_flash_toggle: assert property (wrap |=> phase_r != $past(phase_r))
		else $error("flash phase did not toggle at wrap");
	a_flash_steady: assert property (!wrap |=> $stable(phase_r))
		else $error("flash phase changed mid period");

endmodule

/* File: logic/rcsl_port_lamp.sv */
// Activity lamp of one network port
`timescale 1ns/1ps

module rcsl_port_lamp (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Port state
	input wire logic linkUp,
	input wire logic activity,
	// Shared timing
	input wire logic flashPhase,
	input wire logic testOn,
	// Lamp
	output rcsl_pkg::rcsl_bicolor_type lamp
);

	rcsl_pkg::rcsl_bicolor_type lamp_r; // Registered lamp drive

	assign lamp = lamp_r;

	////////////////////////////////////////////////////////////////
	// Pattern choice, lamp test first
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lamp_r <= '0;
		end else if (testOn) begin
			// Flash test: green flashing
			lamp_r <= '{green: flashPhase, yellow: 1'b0};
		end else if (linkUp && activity) begin
			// Traffic: yellow and green alternate
			lamp_r <= '{green: !flashPhase, yellow: flashPhase};
		end else if (linkUp) begin
			lamp_r <= '{green: 1'b1, yellow: 1'b0};
		end else begin
			lamp_r <= '0;
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_port_dark: assert property (!linkUp && !testOn |=> lamp_r == '0)
		else $error("port lamp lit without link");
	a_port_steady: assert property (linkUp && !activity && !testOn
		|=> lamp_r.green && !lamp_r.yellow)
		else $error("linked port lamp not steady green");

endmodule

/* File: logic/rcsl_status_lamps.sv */
// Status lamp encoder of one CPU in a redundant pair, with APB registers
`timescale 1ns/1ps
`include "rcsl_consts.svh"

module rcsl_status_lamps #(
	parameter int unsigned FLASH_HALF_CYC = `RCSL_FLASH_HALF_CYC,
	parameter int unsigned TEST_CYC = `RCSL_TEST_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Register bus
	input wire rcsl_pkg::rcsl_apb_req_type apbReq,
	output rcsl_pkg::rcsl_apb_rsp_type apbRsp,
	// Port link state, index 0..2 = first port one, two, second port one
	input wire logic [2:0] portLinkUp,
	input wire logic [2:0] portActivity,
	// Front-panel lamps
	output rcsl_pkg::rcsl_lamps_type statusLamps,
	output rcsl_pkg::rcsl_bicolor_type [2:0] portActivityLamp
);

	////////////////////////////////////////////////////////////////
	// Declarations

	rcsl_pkg::rcsl_ctrl_type ctrl_r; // States and role
	rcsl_pkg::rcsl_flags_type flags_r; // Pending conditions
	rcsl_pkg::rcsl_ltstate_type ltState_r; // Lamp test sequencer
	logic [31:0] ltCnt_r; // Cycles spent in lamp test
	rcsl_pkg::rcsl_lamps_type lamps_r; // Registered status lamps
	rcsl_pkg::rcsl_lamps_type lampsNxt; // Chosen lamp pattern
	rcsl_pkg::rcsl_sysstate_type sysState; // Pair state
	logic [31:0] prdata_r; // Read data latched in setup
	logic [1:0] burstLeft_r; // Fault flashes still to show
	logic burstArm_r; // Burst waiting for an on phase
	logic burstOn_r; // Burst flash in progress
	logic cardMaint_r; // Service held after card loss
	logic flashPhase; // Shared flash phase
	logic risePulse; // Phase turns on at next edge
	logic fallPulse; // Phase turns off at next edge
	logic testOn; // Lamp test running
	logic sysRed; // Pair in paired run
	logic ownRed; // This CPU in paired run
	logic greenPath; // Run-state patterns chosen
	logic wrAcc; // Write access phase
	logic setup; // Setup phase
	logic mapped; // Address hits a register
	logic ctrlWr; // Control register written
	logic flagsWr; // Flag register written
	logic insertPulse; // Module insertion restarts test
	logic cardEv; // Card became inaccessible

	////////////////////////////////////////////////////////////////
	// Bus decode

	assign setup = apbReq.psel && !apbReq.penable;
	assign wrAcc = apbReq.psel && apbReq.penable && apbReq.pwrite;
	// Registered addresses
	assign mapped = (apbReq.paddr == `RCSL_CTRL_OFF)
		|| (apbReq.paddr == `RCSL_FLAGS_OFF)
		|| (apbReq.paddr == `RCSL_STATUS_OFF);
	// Writes land on the access edge only
	assign ctrlWr = wrAcc && (apbReq.paddr == `RCSL_CTRL_OFF);
	assign flagsWr = wrAcc && (apbReq.paddr == `RCSL_FLAGS_OFF);
	// Insertion and card loss are write-one events
	assign insertPulse = ctrlWr
		&& apbReq.pwdata[`RCSL_CTRL_INSERT_BIT];
	assign cardEv = flagsWr && ownRed
		&& apbReq.pwdata[`RCSL_FLAGS_CARD_BIT];

	// Zero wait state; unmapped addresses answer with an error
	always_comb begin
		apbRsp.pready = 1'b1;
		apbRsp.pslverr = apbReq.psel && apbReq.penable && !mapped;
		apbRsp.prdata = prdata_r;
	end

	////////////////////////////////////////////////////////////////
	// Read data, latched in the setup cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prdata_r <= 32'h0000_0000;
		end else if (setup && !apbReq.pwrite) begin
			unique case (apbReq.paddr)
				`RCSL_CTRL_OFF: prdata_r <= ctrl_r;
				`RCSL_FLAGS_OFF: prdata_r <= flags_r;
				// Status: lamps, hold, burst, test, pair state
				`RCSL_STATUS_OFF: prdata_r <= {22'h00_0000, lamps_r,
					cardMaint_r, burstOn_r, testOn, sysState};
				default: prdata_r <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Control register; card loss forces single run over a write
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= `RCSL_CTRL_RST;
		end else begin
			if (ctrlWr) begin
				ctrl_r <= apbReq.pwdata;
				// Insertion bit is an event, never stored
				ctrl_r.insertTest <= 1'b0;
			end
			if (cardEv) begin
				ctrl_r.ownState <= rcsl_pkg::OPS_RUN;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Condition flags; card loss bit is an event, never stored
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flags_r <= `RCSL_FLAGS_RST;
		end else if (flagsWr) begin
			flags_r <= apbReq.pwdata;
			flags_r.cardFail <= 1'b0;
			flags_r.rsvd <= '0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Pair state from both operating states
	assign ownRed = (ctrl_r.ownState == rcsl_pkg::OPS_RUN_RED);
	assign sysRed = (sysState == rcsl_pkg::SYS_RUN_RED);

	always_comb begin
		if (ownRed && ctrl_r.partnerState == rcsl_pkg::OPS_RUN_RED) begin
			sysState = rcsl_pkg::SYS_RUN_RED;
		end else if (ctrl_r.ownState inside {rcsl_pkg::OPS_SYNCUP,
			rcsl_pkg::OPS_RUN_SYNCUP} || ctrl_r.partnerState inside
			{rcsl_pkg::OPS_SYNCUP, rcsl_pkg::OPS_RUN_SYNCUP}) begin
			sysState = rcsl_pkg::SYS_SYNCUP;
		end else if (ctrl_r.ownState inside {rcsl_pkg::OPS_RUN,
			rcsl_pkg::OPS_RUN_RED} || ctrl_r.partnerState inside
			{rcsl_pkg::OPS_RUN, rcsl_pkg::OPS_RUN_RED}) begin
			sysState = rcsl_pkg::SYS_RUN_SOLO;
		end else if (ctrl_r.ownState == rcsl_pkg::OPS_STARTUP
			|| ctrl_r.partnerState == rcsl_pkg::OPS_STARTUP) begin
			sysState = rcsl_pkg::SYS_STARTUP;
		end else begin
			sysState = rcsl_pkg::SYS_STOP;
		end
	end

	////////////////////////////////////////////////////////////////
	// Shared flash timing
	rcsl_flash_gen #(
		.HALF_CYC(FLASH_HALF_CYC)
	) u_flash (
		.sys_clk(sys_clk),
		.rst(rst),
		.flashPhase(flashPhase),
		.risePulse(risePulse),
		.fallPulse(fallPulse)
	);

	////////////////////////////////////////////////////////////////
	// Lamp test at reset release and on module insertion
	assign testOn = (ltState_r == rcsl_pkg::LT_TEST);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ltState_r <= rcsl_pkg::LT_TEST;
			ltCnt_r <= 32'h0000_0000;
		end else if (insertPulse) begin
			ltState_r <= rcsl_pkg::LT_TEST;
			ltCnt_r <= 32'h0000_0000;
		end else begin
			unique case (ltState_r)
				rcsl_pkg::LT_TEST: begin
					if (ltCnt_r == 32'(TEST_CYC - 1)) begin
						ltState_r <= rcsl_pkg::LT_NORMAL;
					end
					ltCnt_r <= ltCnt_r + 32'h0000_0001;
				end
				rcsl_pkg::LT_NORMAL: begin
					ltCnt_r <= 32'h0000_0000;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Card loss: three whole fault flashes aligned to the phase
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			burstLeft_r <= 2'h0;
			burstArm_r <= 1'b0;
			burstOn_r <= 1'b0;
		end else if (cardEv) begin
			burstLeft_r <= `RCSL_BURST_FLASHES;
			burstArm_r <= 1'b1;
			burstOn_r <= 1'b0;
		end else if (burstArm_r && risePulse) begin
			// Start with a full on half
			burstOn_r <= 1'b1;
		end else if (burstOn_r && fallPulse) begin
			burstLeft_r <= burstLeft_r - 2'h1;
			if (burstLeft_r == 2'h1) begin
				burstOn_r <= 1'b0;
				burstArm_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Service hold after card loss; a new loss wins over the clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cardMaint_r <= 1'b0;
		end else if (cardEv) begin
			cardMaint_r <= 1'b1;
		end else if (sysRed) begin
			cardMaint_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Pattern choice in fixed priority order
	always_comb begin
		lampsNxt = '0;
		greenPath = 1'b0;
		if (testOn) begin
			lampsNxt.opGreen = flashPhase;
			lampsNxt.opYellow = !flashPhase;
			lampsNxt.faultRed = flashPhase;
			lampsNxt.serviceYellow = flashPhase;
		end else if (flags_r.defective) begin
			// Defective CPU
			lampsNxt.opYellow = 1'b1;
			lampsNxt.faultRed = flashPhase;
			lampsNxt.serviceYellow = flashPhase;
		end else if (flags_r.warmRestart) begin
			lampsNxt.opYellow = flashPhase;
		end else if (!ctrl_r.backupRole
			&& ctrl_r.ownState == rcsl_pkg::OPS_STARTUP) begin
			lampsNxt.opGreen = !flashPhase;
			lampsNxt.opYellow = flashPhase;
			lampsNxt.serviceYellow = 1'b1;
		end else if (ctrl_r.backupRole && flags_r.syncupWait
			&& ctrl_r.ownState == rcsl_pkg::OPS_SYNCUP) begin
			lampsNxt.opGreen = !flashPhase;
			lampsNxt.opYellow = flashPhase;
			lampsNxt.faultRed = flashPhase;
			lampsNxt.serviceYellow = 1'b1;
		end else if (flags_r.fwUpdated) begin
			lampsNxt.opYellow = 1'b1;
			lampsNxt.serviceYellow = flashPhase;
		end else if (flags_r.initDone) begin
			lampsNxt.opYellow = 1'b1;
			lampsNxt.serviceYellow = 1'b1;
		end else if (flags_r.internalAct && !ownRed) begin
			lampsNxt.opYellow = flashPhase;
			lampsNxt.serviceYellow = 1'b1;
		end else if (ctrl_r.ownState == rcsl_pkg::OPS_STOP) begin
			// Stopped CPU
			lampsNxt.opYellow = 1'b1;
		end else begin
			greenPath = 1'b1;
			lampsNxt.opGreen = 1'b1;
			// Diagnostic event or card-loss burst
			lampsNxt.faultRed = (flags_r.diagEvent || burstOn_r)
				&& flashPhase;
			// Service lamp goes dark only paired with no maintenance demand, force, energy pause or card hold
			lampsNxt.serviceYellow = flags_r.maintDemand
				|| flags_r.forceActive || flags_r.energyPause
				|| cardMaint_r || !sysRed;
		end
		// Unpaired backup flashes fault on top; paired, role is unused
		if (!testOn && ctrl_r.backupRole && !sysRed) begin
			lampsNxt.faultRed = flashPhase;
		end
	end

	// Lamps come from flip-flops
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lamps_r <= '0;
		end else begin
			lamps_r <= lampsNxt;
		end
	end

	assign statusLamps = lamps_r;

	////////////////////////////////////////////////////////////////
	// Port activity lamps, one per port
	for (genvar i = 0; i < 3; i++) begin : g_port
		rcsl_port_lamp u_port (
			.sys_clk(sys_clk),
			.rst(rst),
			.linkUp(portLinkUp[i]),
			.activity(portActivity[i]),
			.flashPhase(flashPhase),
			.testOn(testOn),
			.lamp(portActivityLamp[i])
		);
	end

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence sCardLoss;
		cardEv;
	endsequence

	sequence sBurstLast;
		burstOn_r && fallPulse && burstLeft_r == 2'h1;
	endsequence

	a_pair_state: assert property (
		ownRed && ctrl_r.partnerState == rcsl_pkg::OPS_RUN_RED |-> sysRed)
		else $error("paired run not recognised");
	a_test_pattern: assert property (testOn
		|=> lamps_r.faultRed == $past(flashPhase)
		&& lamps_r.opYellow != $past(flashPhase))
		else $error("lamp test pattern wrong");
	a_warm_dark: assert property (!testOn && !flags_r.defective
		&& flags_r.warmRestart && !ctrl_r.backupRole
		|=> !lamps_r.faultRed && !lamps_r.serviceYellow
		&& !lamps_r.opGreen)
		else $error("warm restart pattern wrong");
	a_card_solo: assert property (sCardLoss
		|=> ctrl_r.ownState == rcsl_pkg::OPS_RUN && cardMaint_r)
		else $error("card loss did not leave paired run");
	a_burst_arm: assert property (sCardLoss
		|=> burstLeft_r == 2'h3 && burstArm_r && !burstOn_r)
		else $error("burst not armed with three flashes");
	a_burst_end: assert property (sBurstLast and !cardEv
		|=> !burstOn_r && !burstArm_r && burstLeft_r == 2'h0)
		else $error("burst did not stop after three flashes");
	a_service_hold: assert property (greenPath && cardMaint_r
		|=> lamps_r.serviceYellow)
		else $error("service lamp dropped after card loss");
	a_service_off: assert property (greenPath && !lampsNxt.serviceYellow
		|-> sysRed && !flags_r.maintDemand)
		else $error("service lamp dark outside paired run");
	a_backup_fault: assert property (!testOn && ctrl_r.backupRole
		&& !sysRed |=> lamps_r.faultRed == $past(flashPhase))
		else $error("unpaired backup fault lamp not flashing");
	a_test_length: assert property ($fell(testOn) && !insertPulse
		|-> $past(ltCnt_r) == 32'(TEST_CYC - 1))
		else $error("lamp test length wrong");

endmodule

/* File: dv/rcsl_lamp_viewer.sv */
// Operator's view of the status lamps: counts fault lamp flashes
`timescale 1ns/1ps

module rcsl_lamp_viewer (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Lamps as seen on the panel
	input wire rcsl_pkg::rcsl_lamps_type lamps,
	// Number of times the fault lamp came on
	output int faultRises
);
	// Fault lamp level one cycle ago
	logic faultPrev_r;

	////////////////////////////////////////////////////////////////////////
	// Count each off-to-on change of the fault lamp, as an eye would
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			faultPrev_r <= 1'b0;
			faultRises <= 0;
		end else begin
			faultPrev_r <= lamps.faultRed;
			// A flash begins when the lamp lights up
			if (lamps.faultRed === 1'b1 && faultPrev_r === 1'b0) begin
				faultRises <= faultRises + 1;
			end
		end
	end
endmodule

/* File: dv/tb_rcsl_status_lamps.sv */
// Self-checking testbench of the status lamp encoder
`timescale 1ns/1ps
`include "rcsl_consts.svh"

module tb_rcsl_status_lamps;
	// Clock, reset and design ports
	logic sys_clk;
	logic rst;
	rcsl_pkg::rcsl_apb_req_type apbReq;
	rcsl_pkg::rcsl_apb_rsp_type apbRsp;
	logic [2:0] portLinkUp;
	logic [2:0] portActivity;
	rcsl_pkg::rcsl_lamps_type statusLamps;
	rcsl_pkg::rcsl_bicolor_type [2:0] portActivityLamp;
	// Bookkeeping
	int failures;
	int comparisons;
	int faultRises;
	int startRises;
	logic [31:0] rd;
	logic err;
	// Lit cycles per lamp colour over one window
	logic [4:0] cnt [10];

	// Scenario table: control word, flag word, lamp code {g,y,f,s}
	localparam int NROW = 17;
	localparam logic [31:0] CT [NROW] = '{
		32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0001,
		32'h0000_0042, 32'h0000_0000, 32'h0000_002D, 32'h0000_002D,
		32'h0000_002D, 32'h0000_0004, 32'h0000_0003, 32'h0000_002D,
		32'h0000_002D, 32'h0000_002D, 32'h0000_002D, 32'h0000_002D,
		32'h0000_0044};
	localparam logic [31:0] FL [NROW] = '{
		32'h0000_0001, 32'h0000_0002, 32'h0000_0004, 32'h0000_0000,
		32'h0000_0020, 32'h0000_0008, 32'h0000_0040, 32'h0000_0080,
		32'h0000_0100, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
		32'h0000_0200, 32'h0000_0240, 32'h0000_0011, 32'h0000_000B,
		32'h0000_0000};
	// Rows: x5
	// then
	localparam logic [7:0] CODE [NROW] = '{
		8'h11, 8'h21, 8'h12, 8'hA1, 8'hA9, 8'h20, 8'h41, 8'h41,
		8'h41, 8'h41, 8'h41, 8'h40, 8'h48, 8'h49, 8'h1A, 8'h20,
		8'h49};

	// Design under test with shortened flash and test times
	rcsl_status_lamps #(.FLASH_HALF_CYC(4), .TEST_CYC(20)) i_rcsl_status_lamps (
		.sys_clk(sys_clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
		.portLinkUp(portLinkUp), .portActivity(portActivity),
		.statusLamps(statusLamps), .portActivityLamp(portActivityLamp));

	// Panel observer
	rcsl_lamp_viewer i_rcsl_lamp_viewer (
		.sys_clk(sys_clk), .rst(rst), .lamps(statusLamps),
		.faultRises(faultRises));

	////////////////////////////////////////////////////////////////////////
	// 125 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// Compare and count
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Print counts and verdict, then stop
	task automatic report_and_stop();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// One APB transfer: setup, then access until pready
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
			pwdata: d};
		@(posedge sys_clk);
		apbReq.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (apbRsp.pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			failures++;
		end
		rd = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
	endtask

	// Lit cycles expected for off, steady and flashing
	function automatic logic [4:0] expc(input logic [1:0] c);
		return (c == 2'h1) ? 5'h10 : ((c == 2'h2) ? 5'h08 : 5'h00);
	endfunction

	// Count lit cycles of every lamp colour over two flash periods
	task automatic watch();
		logic [9:0] v;
		for (int i = 0; i < 10; i++) cnt[i] = 5'h00;
		repeat (16) begin
			@(negedge sys_clk);
			v = {statusLamps, portActivityLamp};
			for (int i = 0; i < 10; i++) cnt[i] = cnt[i] + {4'h0, v[9 - i]};
		end
	endtask

	// Check the four status lamps against a {g,y,f,s} code
	task automatic lamps(input logic [7:0] code);
		watch();
		check("status lamps", {12'h000, cnt[0], cnt[1], cnt[2], cnt[3]},
			{12'h000, expc(code[7:6]), expc(code[5:4]), expc(code[3:2]),
			expc(code[1:0])});
	endtask

	// Load both registers, let the lamps settle, then judge them
	task automatic pat(input logic [31:0] c, input logic [31:0] f,
		input logic [7:0] code);
		apb(1'b1, `RCSL_CTRL_OFF, c);
		apb(1'b1, `RCSL_FLAGS_OFF, f);
		repeat (2) @(posedge sys_clk);
		lamps(code);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		apbReq = '0;
		portLinkUp = 3'h0;
		portActivity = 3'h0;
		rst = 1'b1;
		failures = 0;
		comparisons = 0;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		// Lamp test: everything flashes, port lamps flash green
		lamps(8'hAA);
		check("test ports", {2'h0, cnt[4], cnt[6], cnt[8], cnt[5], cnt[7], cnt[9]},
			{2'h0, 5'h08, 5'h08, 5'h08, 15'h0000});
		// Wait for the lamp test to end
		for (int i = 0; i < 20; i++) begin
			apb(1'b0, `RCSL_STATUS_OFF, 32'h0000_0000);
			if (rd[3] === 1'b0) break;
		end
		check("test over", {31'h0000_0000, rd[3]}, 32'h0000_0000);
		// Unmapped address answers zero with an error
		apb(1'b0, 12'h00C, 32'h0000_0000);
		check("unmapped", {rd[31:1], err}, 32'h0000_0001);
		// Pair state from both CPU states
		pat(32'h0000_0000, 32'h0000_0000, 8'h10);
		apb(1'b0, `RCSL_STATUS_OFF, 32'h0000_0000);
		check("pair stop", {29'h0000_0000, rd[2:0]}, 32'h0000_0000);
		apb(1'b1, `RCSL_CTRL_OFF, 32'h0000_0004);
		apb(1'b0, `RCSL_STATUS_OFF, 32'h0000_0000);
		check("pair solo", {29'h0000_0000, rd[2:0]}, 32'h0000_0003);
		// Pattern table
		for (int r = 0; r < NROW; r++) begin
			pat(CT[r], FL[r], CODE[r]);
		end
		apb(1'b0, `RCSL_STATUS_OFF, 32'h0000_0000);
		check("pair solo bk", {29'h0000_0000, rd[2:0]}, 32'h0000_0003);
		// Card loss in paired run
		pat(32'h0000_002D, 32'h0000_0000, 8'h40);
		apb(1'b0, `RCSL_STATUS_OFF, 32'h0000_0000);
		check("pair red", {29'h0000_0000, rd[2:0]}, 32'h0000_0004);
		startRises = faultRises;
		apb(1'b1, `RCSL_FLAGS_OFF, 32'h0000_0400);
		apb(1'b0, `RCSL_CTRL_OFF, 32'h0000_0000);
		check("own state", {29'h0000_0000, rd[2:0]}, 32'h0000_0004);
		apb(1'b0, `RCSL_STATUS_OFF, 32'h0000_0000);
		check("solo after", {29'h0000_0000, rd[2:0]}, 32'h0000_0003);
		repeat (60) @(posedge sys_clk);
		check("flashes", faultRises - startRises, 32'h0000_0003);
		lamps(8'h41);
		pat(32'h0000_002D, 32'h0000_0000, 8'h40);
		// Port lamps: none, link, link with traffic
		@(posedge sys_clk);
		portLinkUp <= 3'h6;
		portActivity <= 3'h4;
		repeat (2) @(posedge sys_clk);
		watch();
		check("ports", {2'h0, cnt[4], cnt[5], cnt[6], cnt[7], cnt[8], cnt[9]},
			{2'h0, 5'h08, 5'h08, 5'h10, 15'h0000});
		// Module insertion restarts the lamp test; the bit reads back 0
		apb(1'b1, `RCSL_CTRL_OFF, 32'h0000_00AD);
		apb(1'b0, `RCSL_STATUS_OFF, 32'h0000_0000);
		check("insert test", {31'h0000_0000, rd[3]}, 32'h0000_0001);
		apb(1'b0, `RCSL_CTRL_OFF, 32'h0000_0000);
		check("insert bit", {24'h00_0000, rd[7:0]}, 32'h0000_002D);
		report_and_stop();
	end

	// Cut a hang short
	initial begin
		#(8 * 8000);
		failures++;
		report_and_stop();
	end
endmodule
